/* File: logic/cvt_pkg.sv */
// constants shared by the comm-verify and tuning-unlock register bank
package cvt_pkg;
	localparam logic [15:0] CVT_ADDR_KEY      = 16'he7fe;
	localparam logic [15:0] CVT_ADDR_TUNE     = 16'he90c;
	localparam logic [15:0] CVT_ADDR_CFG3     = 16'he618;
	localparam logic [15:0] CVT_ADDR_LASTADR  = 16'he9fe;
	localparam logic [15:0] CVT_ADDR_LASTDAT  = 16'he9ff;
	localparam logic [15:0] CVT_WAVE_LO       = 16'he880;
	localparam logic [15:0] CVT_WAVE_HI       = 16'he89f;
	localparam logic [7:0]  CVT_KEY_UNLOCK    = 8'had;
	localparam logic [7:0]  CVT_KEY_RELOCK    = 8'h00;
	localparam logic [15:0] CVT_TUNE_RESET    = 16'h0000;
	localparam logic [7:0]  CVT_CFG3_RESET    = 8'h00;
	localparam int          CVT_CFG3_HPEN_BIT = 0;
	localparam int          CVT_NUM_PATHS     = 7;
	localparam int          CVT_PATH_VC       = 6;
	typedef enum logic [1:0] {
		CVT_LOCKED   = 2'b00,
		CVT_KEYED    = 2'b01,
		CVT_TUNED    = 2'b10
	} cvt_lock_e;
endpackage

/* File: logic/cvt_rdmux.sv */
`timescale 1ns/10ps
// read data selector for the register bank, registered output
module cvt_rdmux
	import cvt_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	// selection
	input  wire logic        rd_stb,
	input  wire logic [15:0] rd_addr,
	input  wire logic [15:0] tune_val,
	input  wire logic [7:0]  cfg3_val,
	input  wire logic [15:0] last_addr_val,
	input  wire logic [31:0] last_data_val,
	input  wire logic [31:0] ext_rdata,
	// result
	output logic      [31:0] rdata
);
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	always_comb begin
		rdata_next = rdata_reg;
		if (rd_stb) begin
			unique case (rd_addr)
				CVT_ADDR_TUNE:    rdata_next = {16'h0000, tune_val};
				CVT_ADDR_CFG3:    rdata_next = {24'h000000, cfg3_val};
				CVT_ADDR_LASTADR: rdata_next = {16'h0000, last_addr_val};
				CVT_ADDR_LASTDAT: rdata_next = last_data_val;
				// key location is write only and reads zero
				CVT_ADDR_KEY:     rdata_next = 32'h00000000;
				default:          rdata_next = ext_rdata;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			rdata_reg <= 32'h00000000;
		else if (clk_en)
			rdata_reg <= rdata_next;
	end

	assign rdata = rdata_reg;
endmodule

/* File: logic/cvt_regbank.sv */
`timescale 1ns/10ps
// comm-verify capture, keyed tuning register and high-pass enable bank
module cvt_regbank
	import cvt_pkg::*;
(
	// clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     sys_rst,
	input  wire logic                     clk_en,
	// register port, one access per strobe, from the serial front end
	input  wire logic                     acc_wr,
	input  wire logic                     acc_rd,
	input  wire logic                     acc_burst_spi,
	input  wire logic [15:0]              acc_addr,
	input  wire logic [31:0]              acc_wdata,
	input  wire logic [31:0]              ext_rdata,
	input  wire logic [31:0]              ext_rdata_next,
	output logic      [31:0]              acc_rdata,
	// comm-verify readback
	output logic      [15:0]              last_access_addr,
	output logic      [31:0]              last_access_data,
	// tuning and filter controls
	output logic      [15:0]              tuning_setting,
	output logic                          tuning_unlocked,
	output logic      [CVT_NUM_PATHS-1:0] highpass_filter_on
);
	cvt_lock_e   lock_reg;
	cvt_lock_e   lock_next;
	logic [15:0] tune_reg;
	logic [15:0] tune_next;
	logic [7:0]  cfg3_reg;
	logic [7:0]  cfg3_next;
	logic [15:0] laddr_reg;
	logic [15:0] laddr_next;
	logic [31:0] ldata_reg;
	logic [31:0] ldata_next;
	logic        any_acc;
	logic        in_wave;
	logic [31:0] rd_word;

	assign any_acc = acc_wr | acc_rd;
	assign in_wave = (acc_addr >= CVT_WAVE_LO) && (acc_addr <= CVT_WAVE_HI);

	// keyed unlock sequence; any stray access drops the key
	always_comb begin
		lock_next = lock_reg;
		tune_next = tune_reg;
		if (any_acc) begin
			unique case (lock_reg)
				CVT_LOCKED: begin
					if (acc_wr && acc_addr == CVT_ADDR_KEY
					    && acc_wdata[7:0] == CVT_KEY_UNLOCK)
						lock_next = CVT_KEYED;
				end
				CVT_KEYED: begin
					if (acc_wr && acc_addr == CVT_ADDR_TUNE) begin
						tune_next = acc_wdata[15:0];
						lock_next = CVT_TUNED;
					end else
						lock_next = CVT_LOCKED;
				end
				CVT_TUNED: begin
					// relock on closing 0x00 or on anything else
					lock_next = CVT_LOCKED;
				end
				default: lock_next = CVT_LOCKED;
			endcase
		end
	end

	// config register: all 8 bits are stored and read back; only the enable bit drives logic here
	always_comb begin
		cfg3_next = cfg3_reg;
		if (acc_wr && acc_addr == CVT_ADDR_CFG3)
			cfg3_next = acc_wdata[7:0];
	end

	// word that a read returns, as seen by the capture logic
	always_comb begin
		unique case (acc_addr)
			CVT_ADDR_TUNE:    rd_word = {16'h0000, tune_reg};
			CVT_ADDR_CFG3:    rd_word = {24'h000000, cfg3_reg};
			CVT_ADDR_LASTADR: rd_word = {16'h0000, laddr_reg};
			CVT_ADDR_LASTDAT: rd_word = ldata_reg;
			CVT_ADDR_KEY:     rd_word = 32'h00000000;
			default:          rd_word = ext_rdata;
		endcase
	end

	// last-access capture; the burst spi waveform slip is reproduced
	always_comb begin
		laddr_next = laddr_reg;
		ldata_next = ldata_reg;
		if (acc_rd) begin
			if (acc_burst_spi && in_wave) begin
				laddr_next = acc_addr + 16'h0001;
				ldata_next = ext_rdata_next;
			end else begin
				// i2c and single spi reads are captured exactly
				laddr_next = acc_addr;
				ldata_next = rd_word;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lock_reg  <= CVT_LOCKED;
			tune_reg  <= CVT_TUNE_RESET;
			cfg3_reg  <= CVT_CFG3_RESET;
			laddr_reg <= 16'h0000;
			ldata_reg <= 32'h00000000;
		end else if (clk_en) begin
			lock_reg  <= lock_next;
			tune_reg  <= tune_next;
			cfg3_reg  <= cfg3_next;
			laddr_reg <= laddr_next;
			ldata_reg <= ldata_next;
		end
	end

	cvt_rdmux u_rdmux (
		.core_clk      (core_clk),
		.sys_rst       (sys_rst),
		.clk_en        (clk_en),
		.rd_stb        (acc_rd),
		.rd_addr       (acc_addr),
		.tune_val      (tune_reg),
		.cfg3_val      (cfg3_reg),
		.last_addr_val (laddr_reg),
		.last_data_val (ldata_reg),
		.ext_rdata     (ext_rdata),
		.rdata         (acc_rdata)
	);

	// filter enables per path: ia ib ic in va vb vc
	genvar gi;
	generate
		for (gi = 0; gi < CVT_NUM_PATHS; gi++) begin : g_hp
			if (gi == CVT_PATH_VC) begin : g_vc
				// silicon fault: no bypass exists for this path
				assign highpass_filter_on[gi] = 1'b1;
			end else begin : g_oth
				assign highpass_filter_on[gi] =
					cfg3_reg[CVT_CFG3_HPEN_BIT];
			end
		end
	endgenerate

	assign last_access_addr = laddr_reg;
	assign last_access_data = ldata_reg;
	assign tuning_setting   = tune_reg;
	assign tuning_unlocked  = (lock_reg == CVT_KEYED);
endmodule

/* File: testbench/cvt_bench.sv */
// self-checking bench for the register bank
`timescale 1ns/10ps
module comm_verify_and_tuning_unlock_bench
	import cvt_pkg::*;
;
	logic core_clk = 0, sys_rst = 1, clk_en = 1, acc_wr = 0, acc_rd = 0;
	logic acc_burst_spi = 0;
	logic [15:0] acc_addr = 16'h0000, la, ts;
	logic [31:0] acc_wdata = 32'h0, xr, xn, rdat, ld;
	logic tu;
	logic [6:0] hp;
	int fail_count = 0, compares = 0;
	cvt_regbank dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.clk_en(clk_en), .acc_wr(acc_wr), .acc_rd(acc_rd),
		.acc_burst_spi(acc_burst_spi), .acc_addr(acc_addr),
		.acc_wdata(acc_wdata), .ext_rdata(xr), .ext_rdata_next(xn),
		.acc_rdata(rdat), .last_access_addr(la), .last_access_data(ld),
		.tuning_setting(ts), .tuning_unlocked(tu),
		.highpass_filter_on(hp));
	cvt_dev_model dev (.acc_addr(acc_addr), .ext_rdata(xr),
		.ext_rdata_next(xn));
	initial forever #10 core_clk = ~core_clk;
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// strobes stay up between calls so back-to-back accesses need no gap
	task acc(input logic w, input logic b, input logic [15:0] a,
		input logic [31:0] d);
		acc_wr = w;
		acc_rd = !w;
		acc_burst_spi = b;
		acc_addr = a;
		acc_wdata = d;
		@(negedge core_clk);
	endtask
	task idle();
		acc_wr = 0;
		acc_rd = 0;
		@(negedge core_clk);
	endtask
	task give_verdict();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#20000;
		fail_count++;
		give_verdict();
	end
	initial begin
		repeat (5) @(negedge core_clk);
		sys_rst = 0;
		chk({25'h0, hp}, 32'h40);
		acc(1, 0, CVT_ADDR_TUNE, 32'h1234);
		idle();
		chk({16'h0, ts}, {16'h0, CVT_TUNE_RESET});
		acc(1, 0, CVT_ADDR_KEY, 32'had);
		chk({31'h0, tu}, 32'h1);
		acc(1, 0, CVT_ADDR_TUNE, 32'h3bd);
		acc(1, 0, CVT_ADDR_KEY, 32'h00);
		acc(0, 0, CVT_ADDR_TUNE, 32'h0);
		chk(rdat, 32'h3bd);
		chk({16'h0, la}, {16'h0, CVT_ADDR_TUNE});
		chk(ld, 32'h3bd);
		acc(1, 0, CVT_ADDR_KEY, 32'had);
		acc(0, 0, CVT_ADDR_CFG3, 32'h0);
		acc(1, 0, CVT_ADDR_TUNE, 32'h1234);
		idle();
		chk({16'h0, ts}, 32'h3bd);
		acc(1, 0, CVT_ADDR_CFG3, 32'h1);
		idle();
		chk({25'h0, hp}, 32'h7f);
		acc(1, 0, CVT_ADDR_CFG3, 32'h0);
		idle();
		chk({25'h0, hp}, 32'h40);
		for (int i = 0; i < 2; i++) begin
			acc(0, 1, i ? CVT_WAVE_HI : CVT_WAVE_LO, 32'h0);
			chk({16'h0, la}, {16'h0, acc_addr + 16'h1});
			chk(ld, {~(acc_addr + 16'h1), acc_addr + 16'h1});
			acc(0, 0, acc_addr, 32'h0);
			chk({16'h0, la}, {16'h0, acc_addr});
			chk(ld, {~acc_addr, acc_addr});
		end
		// a write while the enable is low must leave the config untouched
		clk_en = 0;
		acc(1, 0, CVT_ADDR_CFG3, 32'h1);
		idle();
		clk_en = 1;
		chk({25'h0, hp}, 32'h40);
		idle();
		give_verdict();
	end
endmodule

/* File: testbench/cvt_dev_model.sv */
// model of the rest of the device: word data seen at any address
`timescale 1ns/10ps
module cvt_dev_model (
	// address from the register port
	input  wire logic [15:0] acc_addr,
	// data of the address and of the one after it
	output logic      [31:0] ext_rdata,
	output logic      [31:0] ext_rdata_next
);
	// address-derived data so that an off-by-one read shows up
	assign ext_rdata      = {~acc_addr, acc_addr};
	assign ext_rdata_next = {~(acc_addr + 16'h1), acc_addr + 16'h1};
endmodule

/* File: testbench/cvt_regbank_chk.sv */
// checker for the register bank ports
`timescale 1ns/10ps
module cvt_regbank_chk
	import cvt_pkg::*;
(
	input logic core_clk, sys_rst, clk_en, acc_wr, acc_rd, acc_burst_spi,
	input logic [15:0] acc_addr, last_access_addr, tuning_setting,
	input logic [31:0] acc_wdata, ext_rdata, ext_rdata_next, acc_rdata,
	input logic [31:0] last_access_data,
	input logic tuning_unlocked,
	input logic [CVT_NUM_PATHS-1:0] highpass_filter_on
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic rd, wave, tw;
	assign rd = acc_rd && clk_en;
	assign wave = acc_addr >= CVT_WAVE_LO && acc_addr <= CVT_WAVE_HI;
	assign tw = acc_wr && clk_en && acc_addr == CVT_ADDR_TUNE;
	a_rd_addr_cap: assert property (rd && !acc_burst_spi |=>
		last_access_addr == $past(acc_addr)) else $error("last addr wrong");
	a_rd_data_cap: assert property (rd && !acc_burst_spi |=>
		last_access_data == acc_rdata) else $error("last data wrong");
	a_burst_addr: assert property (rd && acc_burst_spi && wave |=>
		last_access_addr == $past(acc_addr) + 16'h1) else $error("burst adr");
	a_burst_data: assert property (rd && acc_burst_spi && wave |=>
		last_access_data == $past(ext_rdata_next)) else $error("burst dat");
	a_key_unlock: assert property (acc_wr && clk_en &&
		acc_addr == CVT_ADDR_KEY && acc_wdata[7:0] == CVT_KEY_UNLOCK
		|=> tuning_unlocked) else $error("key not taken");
	a_tune_locked: assert property (tw && !tuning_unlocked |=>
		$stable(tuning_setting)) else $error("locked write took");
	a_tune_load: assert property (tw && tuning_unlocked |=>
		tuning_setting == $past(acc_wdata[15:0])) else $error("tune lost");
	a_hp_bypass: assert property (highpass_filter_on[5:0] == 6'h00 ||
		highpass_filter_on[5:0] == 6'h3f) else $error("paths differ");
	a_hp_vc_on: assert property (highpass_filter_on[CVT_PATH_VC])
		else $error("vc filter off");
	c_burst: cover property (rd && acc_burst_spi && wave);
	c_unlock: cover property (tuning_unlocked);
	c_load: cover property (tw && tuning_unlocked);
endmodule
bind cvt_regbank cvt_regbank_chk u_chk (.core_clk(core_clk),
	.sys_rst(sys_rst), .clk_en(clk_en), .acc_wr(acc_wr), .acc_rd(acc_rd),
	.acc_burst_spi(acc_burst_spi), .acc_addr(acc_addr),
	.last_access_addr(last_access_addr), .tuning_setting(tuning_setting),
	.acc_wdata(acc_wdata), .ext_rdata(ext_rdata), .acc_rdata(acc_rdata),
	.ext_rdata_next(ext_rdata_next), .last_access_data(last_access_data),
	.tuning_unlocked(tuning_unlocked),
	.highpass_filter_on(highpass_filter_on));
